// ===== verilog/tcc_pkg.sv
// Summary of operation
// RULE_01: per-comparator enable; off means no result, events
// RULE_02: pin output drives raw result when enabled; code drives the registered polarity-applied result
// RULE_03: invert flips result polarity
// RULE_04: sticky event flag blocks further triggers
// RULE_05: polarity 11 fires on any change
// RULE_06: polarity 10 fires falling, rising if inverted
// RULE_07: polarity 01 fires rising, falling if inverted
// RULE_08: polarity 00 fires nothing
// RULE_09: noninverting select picks ladder or pin A
// RULE_10: inverting select picks B, C, D or band gap
// RULE_11: status shows event flags at bits 10..8
// RULE_12: status shows results at bits 2..0
// RULE_13: idle halt stops all comparators in idle
// RULE_14: ladder has two ranges of 16 levels
// RULE_15: range picks level/24 or quarter plus level/32
// RULE_16: supply select picks reference pins or rails
// RULE_17: ladder power and ladder pin output bits
// RULE_18: reference pin select picks pin or ladder
// RULE_19: band gap select picks full, half, sixth, pin
// RULE_20: software waits for ladder settling
// RULE_21: results synchronised, events are one-cycle pulses
package tcc_pkg;
   localparam int unsigned NUM_COMP = 3;

   // --------------------------------------------------------------
   // register byte addresses
   // --------------------------------------------------------------
   localparam logic [11:0] ADDR_CTRL1  = 12'h000;
   localparam logic [11:0] ADDR_CTRL2  = 12'h004;
   localparam logic [11:0] ADDR_CTRL3  = 12'h008;
   localparam logic [11:0] ADDR_STATUS = 12'h00C;
   localparam logic [11:0] ADDR_LADDER = 12'h010;

   // --------------------------------------------------------------
   // field positions and reset values
   // --------------------------------------------------------------
   localparam int unsigned CTRL_ON_BIT     = 15;
   localparam int unsigned CTRL_PINOE_BIT  = 14;
   localparam int unsigned CTRL_INV_BIT    = 13;
   localparam int unsigned CTRL_EVT_BIT    = 9;
   localparam int unsigned CTRL_RES_BIT    = 8;
   localparam int unsigned CTRL_EVPOL_LSB  = 6;
   localparam int unsigned CTRL_NINV_BIT   = 4;
   localparam int unsigned CTRL_INVSEL_LSB = 0;
   localparam int unsigned STAT_IDLE_BIT   = 15;
   localparam int unsigned STAT_EVT_LSB    = 8;
   localparam int unsigned STAT_RES_LSB    = 0;
   localparam logic [15:0] CTRL_RESET      = 16'h0000;
   localparam logic [15:0] STAT_RESET      = 16'h0000;
   localparam logic [15:0] LADDER_RESET    = 16'h0000;
   localparam logic [15:0] LADDER_WMASK    = 16'h07FF;

   // event polarity codes
   localparam logic [1:0] EVPOL_OFF  = 2'h0;
   localparam logic [1:0] EVPOL_RISE = 2'h1;
   localparam logic [1:0] EVPOL_FALL = 2'h2;
   localparam logic [1:0] EVPOL_ANY  = 2'h3;

   // analog mux selection codes
   typedef enum logic [1:0] {
      TCC_INV_PIN_B = 2'h0,
      TCC_INV_PIN_C = 2'h1,
      TCC_INV_PIN_D = 2'h2,
      TCC_INV_BGAP  = 2'h3
   } tcc_inv_sel_t;

   typedef enum logic [1:0] {
      TCC_BG_FULL  = 2'h0,
      TCC_BG_HALF  = 2'h1,
      TCC_BG_SIXTH = 2'h2,
      TCC_BG_REFP  = 2'h3
   } tcc_bg_sel_t;

   // per-comparator settings to the analog core
   typedef struct packed {
      logic         comparator_on;
      logic         output_invert;
      logic         noninv_input_select;
      tcc_inv_sel_t inv_input_select;
   } tcc_comp_cfg_t;

   // ladder settings to the analog reference
   typedef struct packed {
      logic        ref_pin_select;
      tcc_bg_sel_t bandgap_source_select;
      logic        ladder_power;
      logic        ladder_pin_output;
      logic        ladder_range;
      logic        ladder_supply_select;
      logic [3:0]  ladder_level;
   } tcc_ladder_cfg_t;
endpackage

// ===== verilog/tcc_top.sv
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module tcc_top (
   input  wire logic                                   pclk,
   input  wire logic                                   presetn,
   input  wire logic                                   psel,
   input  wire logic                                   penable,
   input  wire logic                                   pwrite,
   input  wire logic [11:0]                            paddr,
   input  wire logic [31:0]                            pwdata,
   input  wire logic [3:0]                             pstrb,
   output logic      [31:0]                            prdata,
   output logic                                        pready,
   output logic                                        pslverr,
   input  wire logic                                   idle_mode,
   input  wire logic [tcc_pkg::NUM_COMP-1:0]           analog_compare,
   output logic      [tcc_pkg::NUM_COMP-1:0]           comparator_out_pin,
   output logic      [tcc_pkg::NUM_COMP-1:0]           comparator_out_pin_oe_n,
   output logic      [tcc_pkg::NUM_COMP-1:0]           comparator_event,
   output tcc_pkg::tcc_comp_cfg_t [tcc_pkg::NUM_COMP-1:0] comp_cfg,
   output tcc_pkg::tcc_ladder_cfg_t                    ladder_cfg
);

   // --------------------------------------------------------------
   // registers
   // --------------------------------------------------------------
   logic [15:0] ctrl     [tcc_pkg::NUM_COMP];
   logic [tcc_pkg::NUM_COMP-1:0] event_flag;
   logic [tcc_pkg::NUM_COMP-1:0] compare_result;
   logic        idle_halt;
   logic [15:0] ladder;
   logic [tcc_pkg::NUM_COMP-1:0] sync1;
   logic [tcc_pkg::NUM_COMP-1:0] sync2;
   logic [tcc_pkg::NUM_COMP-1:0] active;
   logic [tcc_pkg::NUM_COMP-1:0] fire;
   logic [tcc_pkg::NUM_COMP-1:0] evt_clr;
   logic        wr_acc;
   logic        rd_acc;
   logic        lo_en;
   logic        hi_en;
   logic [15:0] next_rdata;
   logic        hit;

   assign wr_acc = psel & penable & pwrite;
   assign rd_acc = psel & ~penable & ~pwrite;
   assign lo_en  = pstrb[0];
   assign hi_en  = pstrb[1];

   // --------------------------------------------------------------
   // per-comparator logic
   // --------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < tcc_pkg::NUM_COMP; g++) begin : g_comp
         localparam logic [11:0] ADDR = tcc_pkg::ADDR_CTRL1 + 12'(4 * g);
         logic sel;
         logic [1:0] pol;
         logic rise;
         logic fall;
         assign sel = (paddr == ADDR);
         assign pol = ctrl[g][tcc_pkg::CTRL_EVPOL_LSB +: 2];

         // writable control fields; unimplemented bits never stored
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               ctrl[g] <= tcc_pkg::CTRL_RESET;
            end else if (wr_acc && sel) begin
               if (hi_en) begin
                  ctrl[g][15:13] <= pwdata[15:13];
               end
               if (lo_en) begin
                  ctrl[g][7:6] <= pwdata[7:6];
                  ctrl[g][4]   <= pwdata[4];
                  ctrl[g][1:0] <= pwdata[1:0];
               end
            end
         end

         // comparator runs when enabled and not halted by idle
         assign active[g] = ctrl[g][tcc_pkg::CTRL_ON_BIT] & ~(idle_halt & idle_mode); // see RULE_01 see RULE_13

         // two-stage synchroniser on the raw analog decision
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               sync1[g] <= 1'b0;
               sync2[g] <= 1'b0;
            end else begin
               sync1[g] <= analog_compare[g];
               sync2[g] <= sync1[g]; // see RULE_21
            end
         end

         // result with polarity applied; zero while off
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               compare_result[g] <= 1'b0;
            end else begin
               compare_result[g] <= active[g] & (sync2[g] ^ ctrl[g][tcc_pkg::CTRL_INV_BIT]); // see RULE_03 see RULE_01
            end
         end

         // edges of the polarity-applied result; both polarity cases fold in here
         assign rise = active[g] & ~compare_result[g] & (sync2[g] ^ ctrl[g][tcc_pkg::CTRL_INV_BIT]);
         assign fall = active[g] & compare_result[g] & ~(sync2[g] ^ ctrl[g][tcc_pkg::CTRL_INV_BIT]);

         // qualify edges by polarity field; the flag blocks them later, at the flag and pulse registers
         always_comb begin
            case (pol)
               tcc_pkg::EVPOL_ANY:  fire[g] = rise | fall;                          // see RULE_05
               tcc_pkg::EVPOL_FALL: fire[g] = ctrl[g][tcc_pkg::CTRL_INV_BIT] ? rise : fall; // see RULE_06
               tcc_pkg::EVPOL_RISE: fire[g] = ctrl[g][tcc_pkg::CTRL_INV_BIT] ? fall : rise; // see RULE_07
               default:             fire[g] = 1'b0;                                  // see RULE_08
            endcase
         end

         // software may only clear the flag; a clear wins over a fire while the flag is set
         assign evt_clr[g] = wr_acc & sel & hi_en & ~pwdata[tcc_pkg::CTRL_EVT_BIT];

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               event_flag[g] <= 1'b0;
            end else if (fire[g] && !event_flag[g]) begin
               event_flag[g] <= 1'b1; // see RULE_04
            end else if (evt_clr[g]) begin
               event_flag[g] <= 1'b0;
            end
         end

         // single-cycle event pulse, suppressed while flag stands
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               comparator_event[g] <= 1'b0;
            end else begin
               comparator_event[g] <= fire[g] & ~event_flag[g]; // see RULE_04 see RULE_21
            end
         end

         // pin path: pad enable and analog core settings; the pin takes the synchronised result
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               comparator_out_pin_oe_n[g] <= 1'b1;
               comp_cfg[g]                <= '0;
            end else begin
               comparator_out_pin_oe_n[g] <= ~(ctrl[g][tcc_pkg::CTRL_PINOE_BIT] & active[g]); // see RULE_02
               comp_cfg[g].comparator_on       <= active[g];
               comp_cfg[g].output_invert       <= ctrl[g][tcc_pkg::CTRL_INV_BIT];
               comp_cfg[g].noninv_input_select <= ctrl[g][tcc_pkg::CTRL_NINV_BIT]; // see RULE_09
               comp_cfg[g].inv_input_select    <=
                  tcc_pkg::tcc_inv_sel_t'(ctrl[g][tcc_pkg::CTRL_INVSEL_LSB +: 2]); // see RULE_10
            end
         end

         // registered copy of the result for the pin driver
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               comparator_out_pin[g] <= 1'b0;
            end else begin
               comparator_out_pin[g] <= compare_result[g];
            end
         end
      end
   endgenerate

   // --------------------------------------------------------------
   // shared status and ladder registers
   // --------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idle_halt <= tcc_pkg::STAT_RESET[tcc_pkg::STAT_IDLE_BIT];
      end else if (wr_acc && paddr == tcc_pkg::ADDR_STATUS && hi_en) begin
         idle_halt <= pwdata[tcc_pkg::STAT_IDLE_BIT]; // see RULE_13
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ladder <= tcc_pkg::LADDER_RESET;
      end else if (wr_acc && paddr == tcc_pkg::ADDR_LADDER) begin
         if (lo_en) begin
            ladder[7:0] <= pwdata[7:0]; // see RULE_14 see RULE_16
         end
         if (hi_en) begin
            ladder[15:8] <= pwdata[15:8] & tcc_pkg::LADDER_WMASK[15:8];
         end
      end
   end

   // ladder settings to the analog reference; the ladder itself
   // forms span/24 steps or span/4 plus span/32 steps from range
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ladder_cfg <= '0;
      end else begin
         ladder_cfg.ref_pin_select        <= ladder[10];                         // see RULE_18
         ladder_cfg.bandgap_source_select <= tcc_pkg::tcc_bg_sel_t'(ladder[9:8]); // see RULE_19
         ladder_cfg.ladder_power          <= ladder[7];                          // see RULE_17
         ladder_cfg.ladder_pin_output     <= ladder[6];                          // see RULE_17
         ladder_cfg.ladder_range          <= ladder[5];                          // see RULE_15
         ladder_cfg.ladder_supply_select  <= ladder[4];                          // see RULE_16
         ladder_cfg.ladder_level          <= ladder[3:0];                        // see RULE_14
      end
   end

   // --------------------------------------------------------------
   // apb read path: zero-wait, data registered in setup
   // --------------------------------------------------------------
   always_comb begin
      next_rdata = 16'h0000;
      hit        = 1'b1;
      case (paddr)
         tcc_pkg::ADDR_CTRL1, tcc_pkg::ADDR_CTRL2, tcc_pkg::ADDR_CTRL3: begin
            for (int i = 0; i < tcc_pkg::NUM_COMP; i++) begin
               if (paddr == tcc_pkg::ADDR_CTRL1 + 12'(4 * i)) begin
                  next_rdata = ctrl[i];
                  next_rdata[tcc_pkg::CTRL_EVT_BIT] = event_flag[i];
                  next_rdata[tcc_pkg::CTRL_RES_BIT] = compare_result[i];
               end
            end
         end
         tcc_pkg::ADDR_STATUS: begin
            next_rdata[tcc_pkg::STAT_IDLE_BIT] = idle_halt;
            next_rdata[tcc_pkg::STAT_EVT_LSB +: 3] = event_flag;     // see RULE_11
            next_rdata[tcc_pkg::STAT_RES_LSB +: 3] = compare_result; // see RULE_12
         end
         tcc_pkg::ADDR_LADDER: begin
            next_rdata = ladder;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
         pready  <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         if (psel && !penable) begin
            prdata  <= rd_acc ? {16'h0000, next_rdata} : 32'h00000000;
            pslverr <= ~hit;
         end else begin
            pslverr <= 1'b0; // error stands only beside ready
         end
      end
   end

endmodule

// ===== tb/tcc_top_properties.sv
`timescale 1ns/1ns
module tcc_top_properties (
   input wire logic                          pclk,
   input wire logic                          presetn,
   input wire logic                          psel,
   input wire logic                          penable,
   input wire logic                          pwrite,
   input wire logic [11:0]                   paddr,
   input wire logic [31:0]                   pwdata,
   input wire logic [3:0]                    pstrb,
   input wire logic                          pready,
   input wire logic                          pslverr,
   input wire logic [2:0]                    analog_compare,
   input wire logic [2:0]                    comparator_out_pin,
   input wire logic [2:0]                    comparator_out_pin_oe_n,
   input wire logic [2:0]                    comparator_event,
   input tcc_pkg::tcc_comp_cfg_t [2:0]       comp_cfg,
   input tcc_pkg::tcc_ladder_cfg_t           ladder_cfg
);
   logic [10:0] lad_exp;
   wire         wr_lad = psel && penable && pready && pwrite && paddr == tcc_pkg::ADDR_LADDER && pstrb == 4'hF;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // last full-word ladder write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         lad_exp <= 11'h000;
      else if (wr_lad)
         lad_exp <= pwdata[10:0];
   end
   property p_zero_wait; psel && !penable |=> pready; endproperty
   a_zero_wait: assert property (p_zero_wait) else $error("no ready after setup");
   property p_ready_once; pready |=> !pready; endproperty
   a_ready_once: assert property (p_ready_once) else $error("ready held");
   property p_err_ready; pslverr |-> pready; endproperty
   a_err_ready: assert property (p_err_ready) else $error("error without ready");
   property p_evt_pulse; comparator_event[0] |=> !comparator_event[0]; endproperty
   a_evt_pulse: assert property (p_evt_pulse) else $error("event not one cycle");
   property p_off_quiet; (!comp_cfg[0].comparator_on)[*3] |-> !comparator_event[0] && comparator_out_pin_oe_n[0]; endproperty
   a_off_quiet: assert property (p_off_quiet) else $error("disabled comparator active");
   property p_pin_result;
      (!comparator_out_pin_oe_n[0] && $stable(analog_compare[0]) && $stable(comp_cfg[0]))[*8]
      |-> comparator_out_pin[0] == (analog_compare[0] ^ comp_cfg[0].output_invert);
   endproperty
   a_pin_result: assert property (p_pin_result) else $error("pin shows wrong result");
   property p_stable_quiet;
      (comp_cfg[0].comparator_on && $stable(analog_compare[0]) && $stable(comp_cfg[0]))[*8] |-> !comparator_event[0];
   endproperty
   a_stable_quiet: assert property (p_stable_quiet) else $error("event without change");
   property p_ladder; wr_lad |-> ##[1:2] ladder_cfg == lad_exp; endproperty
   a_ladder: assert property (p_ladder) else $error("ladder settings lag");
   c_event: cover property (comparator_event[0]);
   c_err: cover property (pslverr);
   c_ladder: cover property (wr_lad);
endmodule
bind tcc_top tcc_top_properties chk_u (.*);

// ===== tb/tcc_analog_model.sv
`timescale 1ns/1ns
module tcc_analog_model (
   input  wire logic                    pclk,
   input  wire logic [2:0]              plus_above,
   input  tcc_pkg::tcc_comp_cfg_t [2:0] comp_cfg,
   output logic [2:0]                   analog_compare
);
   logic flip = 1'h0;
   // a powered-down core decides nothing: it chatters
   always @(posedge pclk) flip <= ~flip;
   // raw decision, plus input above minus input
   always_comb begin
      for (int i = 0; i < 3; i++)
         analog_compare[i] = comp_cfg[i].comparator_on ? plus_above[i] : flip;
   end
endmodule

// ===== tb/triple_comparator_control_tb.sv
`timescale 1ns/1ns
module triple_comparator_control_tb;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, idle_mode = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [3:0]  pstrb = 4'h0;
   logic [2:0]  plus_above = 3'h0, analog_compare, out_pin, oe_n, comparator_event;
   logic        pready, pslverr;
   tcc_pkg::tcc_comp_cfg_t [2:0] comp_cfg;
   tcc_pkg::tcc_ladder_cfg_t     ladder_cfg;
   int fail_count = 0, num_checks = 0, ev_cnt = 0;
   tcc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .idle_mode(idle_mode), .analog_compare(analog_compare), .comparator_out_pin(out_pin),
      .comparator_out_pin_oe_n(oe_n), .comparator_event(comparator_event), .comp_cfg(comp_cfg),
      .ladder_cfg(ladder_cfg));
   tcc_analog_model model_u (.pclk(pclk), .plus_above(plus_above), .comp_cfg(comp_cfg),
      .analog_compare(analog_compare));
   initial forever #4 pclk = ~pclk;
   // counts event pulses of all comparators
   always @(posedge pclk) ev_cnt <= ev_cnt + $countones(comparator_event);
   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // one APB transfer, held until ready is sampled
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] r, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      if (pready !== 1'h1) begin
         fail_count++;
         finish_test();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'h0; penable <= 1'h0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'h1, a, d, 4'hF, r, e);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic e;
      apb(1'h0, a, 32'h0, 4'h0, r, e);
      chk(r, x);
   endtask
   task automatic test_regs;
      logic [31:0] r;
      logic e;
      for (int k = 0; k < 5; k++) rdc(12'(4 * k), 32'h0);
      apb(1'h1, 12'h020, 32'hFFFF, 4'hF, r, e);
      chk(e, 32'h1);
      apb(1'h0, 12'h020, 32'h0, 4'h0, r, e);
      chk({r[30:0], e}, 32'h1);
      wr(tcc_pkg::ADDR_LADDER, 32'hFFFFFFFF);
      settle(2);
      chk(ladder_cfg, 32'h7FF);
      apb(1'h1, tcc_pkg::ADDR_LADDER, 32'h155, 4'h1, r, e);
      rdc(tcc_pkg::ADDR_LADDER, 32'h755);
      $display("test_regs done");
   endtask
   task automatic test_events;
      logic [31:0] c;
      for (int k = 0; k < 8; k++) begin
         c = {16'h0, 2'h3, k[2], 5'h0, k[1:0], 6'h0};
         plus_above[0] <= 1'h0;
         wr(tcc_pkg::ADDR_CTRL1, c);
         settle(12);
         wr(tcc_pkg::ADDR_CTRL1, c);
         ev_cnt = 0;
         plus_above[0] <= 1'h1;
         settle(10);
         chk(ev_cnt, k[0]);
         chk({oe_n[0], out_pin[0]}, !k[2]);
         rdc(tcc_pkg::ADDR_STATUS, {23'h0, k[0], 7'h0, !k[2]});
         wr(tcc_pkg::ADDR_CTRL1, c);
         ev_cnt = 0;
         plus_above[0] <= 1'h0;
         settle(10);
         chk(ev_cnt, k[1]);
         if (k[1:0] == 2'h3) begin
            ev_cnt = 0;
            plus_above[0] <= 1'h1;
            settle(8);
            plus_above[0] <= 1'h0;
            settle(8);
            chk(ev_cnt, 32'h0);
         end
      end
      $display("test_events done");
   endtask
   task automatic test_idle;
      wr(tcc_pkg::ADDR_CTRL1, 32'h8000);
      wr(tcc_pkg::ADDR_STATUS, 32'h8000);
      idle_mode <= 1'h1;
      settle(4);
      chk(comp_cfg[0].comparator_on, 32'h0);
      rdc(tcc_pkg::ADDR_STATUS, 32'h8000);
      idle_mode <= 1'h0;
      settle(4);
      chk(comp_cfg[0].comparator_on, 32'h1);
      wr(tcc_pkg::ADDR_STATUS, 32'h0);
      idle_mode <= 1'h1;
      settle(4);
      chk(comp_cfg[0].comparator_on, 32'h1);
      idle_mode <= 1'h0;
      $display("test_idle done");
   endtask
   task automatic test_mux;
      for (int i = 0; i < 3; i++) begin
         for (int c = 0; c < 4; c++) begin
            wr(12'(4 * i), {16'h0, 14'h2004, c[1:0]});
            settle(2);
            chk(comp_cfg[i], {3'h5, c[1:0]});
         end
      end
      plus_above <= 3'h5;
      settle(10);
      rdc(tcc_pkg::ADDR_STATUS, 32'h5);
      chk(out_pin, 32'h5);
      wr(tcc_pkg::ADDR_CTRL3, 32'h80D3);
      ev_cnt = 0;
      plus_above[2] <= 1'h0;
      settle(10);
      chk(ev_cnt, 32'h1);
      chk(out_pin, 32'h1);
      rdc(tcc_pkg::ADDR_STATUS, 32'h401);
      chk(oe_n, 32'h7);
      $display("test_mux done");
   endtask
   initial begin
      settle(2);
      presetn <= 1'h1;
      test_regs();
      test_events();
      test_idle();
      test_mux();
      finish_test();
   end
endmodule
